// [hdl/meter_irq_core.sv]
// Peak detection, peak hold, event flags, interrupt line, temperature
// sequencing and the serial register port of the metering device.
// Assumes converter samples and zero-crossing pulses arrive on i_clk,
// and that the serial master holds chip select high while i_rst is high.
`timescale 1ns/100ps

module meter_irq_core (
    // Master clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    // Converter side
    input  wire meter_irq_pkg::sample_t   i_sample,
    input  wire logic                     i_zero_cross,
    input  wire logic [7:0]               i_temp_code,
    output logic                          o_temp_route,
    // Serial port
    input  wire logic                     i_sclk,
    input  wire logic                     i_cs_n,
    input  wire logic                     i_din,
    output logic                          o_dout,
    output logic                          o_dout_oe,
    // Open-drain interrupt line, active low
    output logic                          o_irq_n,
    output logic                          o_irq_oe
);

    // ---------------- Serial clock domain ----------------
    logic [4:0]  bit_cnt_q;     // Bits taken this frame
    logic [7:0]  cmd_q;         // Command byte
    logic [23:0] shin_q;        // Incoming bit shifter
    logic        rd_pend_q;     // Read command seen
    logic        wr_pend_q;     // Write data complete
    logic        done_pend_q;   // Read data fully shifted
    logic        hold_q;        // Clearing read in progress
    logic [23:0] shout_q;       // Outgoing bit shifter
    logic        dout_q;        // Output bit
    meter_irq_pkg::reg_write_t wr_q;  // Captured write

    // Named decode of the serial frame
    wire  [7:0]  cmd_now   = {shin_q[6:0], i_din};
    wire  [5:0]  cmd_addr  = cmd_q[5:0];
    wire         cmd_wr    = cmd_q[meter_irq_pkg::CMD_WRITE_BIT];
    wire  [4:0]  last_bit  = {meter_irq_pkg::xfer_bytes(cmd_addr), 3'b111};
    wire         cmd_end   = (bit_cnt_q == 5'd7);
    wire         data_end  = (bit_cnt_q == last_bit) && (bit_cnt_q > 5'd7);
    wire         now_is_rc = (cmd_now[5:0] == meter_irq_pkg::ADDR_FLAGS_RC);

    // Bit counter and frame levels; chip select high ends the frame
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            bit_cnt_q   <= 5'd0;
            rd_pend_q   <= 1'b0;
            wr_pend_q   <= 1'b0;
            done_pend_q <= 1'b0;
            hold_q      <= 1'b0;
        end else begin
            if (bit_cnt_q != 5'd31) begin
                bit_cnt_q <= bit_cnt_q + 5'd1;
            end
            if (cmd_end && !cmd_now[meter_irq_pkg::CMD_WRITE_BIT]) begin
                rd_pend_q <= 1'b1;
                hold_q    <= now_is_rc;  // Release line on command's last edge
            end
            if (data_end && cmd_wr) begin
                wr_pend_q <= 1'b1;
            end
            if (data_end && !cmd_wr) begin
                done_pend_q <= 1'b1;     // Read complete, clears follow
                hold_q      <= 1'b0;     // Line may return after last bit
            end
        end
    end

    // Data capture; stays steady until the next frame overwrites it
    always_ff @(negedge i_sclk) begin
        shin_q <= {shin_q[22:0], i_din};
        if (cmd_end) begin
            cmd_q <= cmd_now;
        end
        if (data_end && cmd_wr) begin
            wr_q.addr <= cmd_addr;
            wr_q.data <= {shin_q[14:0], i_din};
        end
    end

    // Read word held by the master domain, stable after the command wait
    logic [23:0] rd_word_q;

    // Output shifter, changes on the rising serial edge
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            shout_q <= 24'h00_0000;
            dout_q  <= 1'b0;
        end else if (bit_cnt_q == 5'd8 && !cmd_wr) begin
            shout_q <= {rd_word_q[22:0], 1'b0};
            dout_q  <= rd_word_q[23];
        end else begin
            shout_q <= {shout_q[22:0], 1'b0};
            dout_q  <= shout_q[23];
        end
    end

    // Output drives only while selected
    assign o_dout    = dout_q;
    assign o_dout_oe = !i_cs_n;

    // ---------------- Master clock domain ----------------
    // Two-stage synchronisers plus an edge stage for the frame levels
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;
    wire  [3:0] link_lvl = {hold_q, done_pend_q, wr_pend_q, rd_pend_q};

    // Synchroniser chain
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
        end else begin
            sync1_q <= link_lvl;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Crossed events
    wire rd_rise   = sync2_q[0] && !sync3_q[0];
    wire wr_rise   = sync2_q[1] && !sync3_q[1];
    wire done_rise = sync2_q[2] && !sync3_q[2];
    // Extra cycle on the fall hides the flag clear from the line
    wire rd_hold   = sync2_q[3] || sync3_q[3];

    // Registers
    logic [15:0] mode_q, mode_d;        // Mode register
    logic [15:0] irq_en_q;              // irq_enable_mask
    logic [15:0] flags_q, flags_d;      // irq_flags
    logic [15:0] snap_q;                // Reported flags with no newer event
    logic [7:0]  vthr_q;                // voltage_peak_threshold
    logic [7:0]  ithr_q;                // current_peak_threshold
    logic [23:0] vhold_q, vhold_d;      // voltage_peak_hold
    logic [23:0] ihold_q, ihold_d;      // current_peak_hold
    logic [7:0]  temp_q;                // die_temperature
    logic [5:0]  rd_addr_q;             // Address of the read in flight
    logic        irq_oe_q;              // Registered line drive

    // Magnitudes; the doubled form feeds both compare and voltage hold
    wire  [23:0] v_abs    = meter_irq_pkg::abs24(i_sample.volt);
    wire  [23:0] i_abs    = meter_irq_pkg::abs24(i_sample.curr);
    wire  [23:0] v_dbl    = {v_abs[22:0], 1'b0};
    wire  [23:0] i_dbl    = {i_abs[22:0], 1'b0};
    // Top byte strictly above threshold; 0xFF equals full scale
    wire         v_pk_evt = i_sample.valid && (v_dbl[23:16] > vthr_q);
    wire         i_pk_evt = i_sample.valid && (i_dbl[23:16] > ithr_q);

    // Temperature sequencer
    typedef enum logic [2:0] {
        T_IDLE  = 3'b001,
        T_ARMED = 3'b010,
        T_CONV  = 3'b100
    } temp_state_t;
    temp_state_t tstate_q, tstate_d;
    logic [7:0]  tcnt_q, tcnt_d;
    wire         temp_done = (tstate_q == T_CONV) && (tcnt_q == 8'd0);

    // Event vector
    logic [15:0] events;
    always_comb begin
        events                               = 16'h0000;
        events[meter_irq_pkg::FLAG_V_PEAK]   = v_pk_evt;
        events[meter_irq_pkg::FLAG_I_PEAK]   = i_pk_evt;
        events[meter_irq_pkg::FLAG_TEMP]     = temp_done;
    end

    // Clears applied once the read data has left the device
    wire         clr_flags = done_rise && (rd_addr_q == meter_irq_pkg::ADDR_FLAGS_RC);
    wire         clr_v     = done_rise && (rd_addr_q == meter_irq_pkg::ADDR_V_HOLD_RC);
    wire         clr_i     = done_rise && (rd_addr_q == meter_irq_pkg::ADDR_I_HOLD_RC);
    // Only the reported bits are cleared, newer events survive
    wire  [15:0] clr_mask  = clr_flags ? snap_q : 16'h0000;
    // Set wins over clear, independent of enables
    assign flags_d = (flags_q & ~clr_mask) | events;

    // Peak holds; a sample in the clearing cycle still counts
    wire  [23:0] vbase = clr_v ? meter_irq_pkg::PEAK_RESET : vhold_q;
    wire  [23:0] ibase = clr_i ? meter_irq_pkg::PEAK_RESET : ihold_q;
    assign vhold_d = (i_sample.valid && v_dbl > vbase) ? v_dbl : vbase;
    assign ihold_d = (i_sample.valid && i_abs > ibase) ? i_abs : ibase;

    // Write decode
    wire wr_mode = wr_rise && (wr_q.addr == meter_irq_pkg::ADDR_MODE);
    wire wr_en   = wr_rise && (wr_q.addr == meter_irq_pkg::ADDR_IRQ_ENABLE);
    wire wr_vthr = wr_rise && (wr_q.addr == meter_irq_pkg::ADDR_VPK_THR);
    wire wr_ithr = wr_rise && (wr_q.addr == meter_irq_pkg::ADDR_IPK_THR);

    // Mode: arm bit drops when the conversion completes unless rewritten
    always_comb begin
        mode_d = mode_q;
        if (temp_done) begin
            mode_d[meter_irq_pkg::MODE_TEMP_ARM] = 1'b0;
        end
        if (wr_mode) begin
            mode_d = wr_q.data;
        end
    end

    // Temperature sequencer next state
    always_comb begin
        tstate_d = tstate_q;
        tcnt_d   = tcnt_q;
        case (tstate_q)
            T_IDLE: begin
                if (mode_q[meter_irq_pkg::MODE_TEMP_ARM]) begin
                    tstate_d = T_ARMED;
                end
            end
            T_ARMED: begin
                if (!mode_q[meter_irq_pkg::MODE_TEMP_ARM]) begin
                    tstate_d = T_IDLE;
                end else if (i_zero_cross) begin
                    tstate_d = T_CONV;  // Start at the zero crossing
                    tcnt_d   = 8'(meter_irq_pkg::TEMP_DELAY_CLKS - 1);
                end
            end
            T_CONV: begin
                if (tcnt_q == 8'd0) begin
                    tstate_d = T_IDLE;
                end else begin
                    tcnt_d = tcnt_q - 8'd1;
                end
            end
            default: begin
                tstate_d = T_IDLE;
                tcnt_d   = 8'd0;
            end
        endcase
    end

    // Sensor steered to the current converter while converting
    assign o_temp_route = (tstate_q == T_CONV);

    // Read mux for the register named by the command
    logic [23:0] rd_val;
    always_comb begin
        case (cmd_addr)
            meter_irq_pkg::ADDR_MODE:       rd_val = {8'h00, mode_q};
            meter_irq_pkg::ADDR_IRQ_ENABLE: rd_val = {8'h00, irq_en_q};
            meter_irq_pkg::ADDR_FLAGS:      rd_val = {8'h00, flags_q};
            meter_irq_pkg::ADDR_FLAGS_RC:   rd_val = {8'h00, flags_q};
            meter_irq_pkg::ADDR_VPK_THR:    rd_val = {16'h0000, vthr_q};
            meter_irq_pkg::ADDR_IPK_THR:    rd_val = {16'h0000, ithr_q};
            meter_irq_pkg::ADDR_V_HOLD,
            meter_irq_pkg::ADDR_V_HOLD_RC:  rd_val = vhold_q;
            meter_irq_pkg::ADDR_I_HOLD,
            meter_irq_pkg::ADDR_I_HOLD_RC:  rd_val = ihold_q;
            meter_irq_pkg::ADDR_TEMP:       rd_val = {16'h0000, temp_q};
            default:                        rd_val = 24'h00_0000;
        endcase
    end
    // Left-justify so the first shifted bit is the word's top bit
    wire [4:0]  rd_shift = {2'd3 - meter_irq_pkg::xfer_bytes(cmd_addr), 3'b000};
    wire [23:0] rd_left  = rd_val << rd_shift;

    // Interrupt: enabled flag pulls low unless a clearing read holds it off
    wire irq_want = (|(flags_q & irq_en_q)) && !rd_hold;

    // Register state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_q    <= meter_irq_pkg::MODE_RESET;
            irq_en_q  <= meter_irq_pkg::IRQ_EN_RESET;
            flags_q   <= 16'h0000;
            snap_q    <= 16'h0000;
            vthr_q    <= meter_irq_pkg::THR_RESET;
            ithr_q    <= meter_irq_pkg::THR_RESET;
            vhold_q   <= meter_irq_pkg::PEAK_RESET;
            ihold_q   <= meter_irq_pkg::PEAK_RESET;
            temp_q    <= meter_irq_pkg::TEMP_RESET;
            rd_addr_q <= 6'h00;
            rd_word_q <= 24'h00_0000;
            tstate_q  <= T_IDLE;
            tcnt_q    <= 8'd0;
            irq_oe_q  <= 1'b0;
        end else begin
            mode_q   <= mode_d;
            flags_q  <= flags_d;
            vhold_q  <= vhold_d;
            ihold_q  <= ihold_d;
            snap_q   <= snap_q & ~events;  // A bit that fires again survives the clear
            tstate_q <= tstate_d;
            tcnt_q   <= tcnt_d;
            irq_oe_q <= irq_want;
            if (wr_en) begin
                irq_en_q <= wr_q.data;
            end
            if (wr_vthr) begin
                vthr_q <= wr_q.data[7:0];
            end
            if (wr_ithr) begin
                ithr_q <= wr_q.data[7:0];
            end
            if (temp_done) begin
                temp_q <= i_temp_code;  // Signed code kept as is
            end
            if (rd_rise) begin
                rd_addr_q <= cmd_addr;
                rd_word_q <= rd_left;
                snap_q    <= flags_q & ~events;
            end
        end
    end

    // Open-drain line: value low, enable high while pulling
    assign o_irq_n  = 1'b0;
    assign o_irq_oe = irq_oe_q;

    // ---------------- Checks ----------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_v_set;
        v_pk_evt |=> flags_q[meter_irq_pkg::FLAG_V_PEAK];
    endproperty
    a_v_set: assert property (p_v_set) else $error("voltage peak flag missed");

    property p_i_set;
        (i_sample.valid && i_dbl[23:16] > ithr_q) |=> flags_q[meter_irq_pkg::FLAG_I_PEAK];
    endproperty
    a_i_set: assert property (p_i_set) else $error("current peak flag missed");

    property p_v_cause;
        $rose(flags_q[meter_irq_pkg::FLAG_V_PEAK])
            |-> $past(i_sample.valid && v_dbl[23:16] > vthr_q);
    endproperty
    a_v_cause: assert property (p_v_cause) else $error("voltage flag without cause");

    property p_irq_follows;
        (|(flags_q & irq_en_q)) && !rd_hold ##1 (|(flags_q & irq_en_q)) && !rd_hold
            |-> irq_oe_q;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("line not pulled");

    property p_hold_release;
        rd_hold |=> !irq_oe_q;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("line pulled in read");

    property p_vhold_update;
        (i_sample.valid && !clr_v && v_dbl > vhold_q) |=> vhold_q == $past(v_dbl);
    endproperty
    a_vhold_update: assert property (p_vhold_update) else $error("voltage hold stale");

    sequence s_temp_start;
        (tstate_q == T_ARMED) && mode_q[meter_irq_pkg::MODE_TEMP_ARM] && i_zero_cross;
    endsequence
    property p_temp_delay;
        s_temp_start |-> ##96 temp_done ##1 flags_q[meter_irq_pkg::FLAG_TEMP];
    endproperty
    a_temp_delay: assert property (p_temp_delay) else $error("temperature timing wrong");

    property p_flags_clear;
        clr_flags |=> ((flags_q & $past(snap_q) & ~$past(events)) == 16'h0000);
    endproperty
    a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared");

    property p_en_write;
        wr_en |=> irq_en_q == $past(wr_q.data);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost");

endmodule : meter_irq_core

// [shared/meter_irq_pkg.sv]
// Shared constants, carriers and helpers for the metering event block.
// Assumes one master clock domain plus the serial port clock domain.
package meter_irq_pkg;

    // Serial register map (6-bit register addresses)
    localparam int           ADDR_W          = 6;
    localparam logic [5:0]   ADDR_MODE       = 6'h09;
    localparam logic [5:0]   ADDR_IRQ_ENABLE = 6'h0A;
    localparam logic [5:0]   ADDR_FLAGS      = 6'h0B;
    localparam logic [5:0]   ADDR_FLAGS_RC   = 6'h0C;
    localparam logic [5:0]   ADDR_IPK_THR    = 6'h20;
    localparam logic [5:0]   ADDR_VPK_THR    = 6'h21;
    localparam logic [5:0]   ADDR_I_HOLD     = 6'h22;
    localparam logic [5:0]   ADDR_I_HOLD_RC  = 6'h23;
    localparam logic [5:0]   ADDR_V_HOLD     = 6'h24;
    localparam logic [5:0]   ADDR_V_HOLD_RC  = 6'h25;
    localparam logic [5:0]   ADDR_TEMP       = 6'h26;

    // Command byte and field positions
    localparam int           CMD_WRITE_BIT   = 7;
    localparam int           FLAG_TEMP       = 5;
    localparam int           FLAG_I_PEAK     = 7;
    localparam int           FLAG_V_PEAK     = 8;
    localparam int           MODE_TEMP_ARM   = 5;

    // Reset values and the magnitude saturation limit
    localparam logic [15:0]  MODE_RESET      = 16'h0000;
    localparam logic [15:0]  IRQ_EN_RESET    = 16'h0000;
    localparam logic [7:0]   THR_RESET       = 8'hFF;
    localparam logic [23:0]  PEAK_RESET      = 24'h00_0000;
    localparam logic [7:0]   TEMP_RESET      = 8'h00;
    localparam logic [23:0]  ABS_MAX         = 24'h7F_FFFF;

    // Temperature result delay, in master clock periods, and as i_clk cycles
    localparam int           TEMP_DELAY_PERIODS = 96;
    localparam int           MASTER_PERIOD_PS   = 8000;
    localparam int           CLK_PERIOD_PS      = 8000;
    localparam int           TEMP_DELAY_CLKS    =
        (TEMP_DELAY_PERIODS * MASTER_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // One converter sample pair
    typedef struct packed {
        logic               valid;
        logic signed [23:0] volt;
        logic signed [23:0] curr;
    } sample_t;

    // One register write crossing from the serial port
    typedef struct packed {
        logic [5:0]  addr;
        logic [15:0] data;
    } reg_write_t;

    // Data bytes that follow the command byte for a register
    function automatic logic [1:0] xfer_bytes(input logic [5:0] a);
        logic [1:0] n;
        n = 2'd1;
        if (a == ADDR_MODE || a == ADDR_IRQ_ENABLE || a == ADDR_FLAGS || a == ADDR_FLAGS_RC)
            n = 2'd2;
        else if (a == ADDR_I_HOLD || a == ADDR_I_HOLD_RC ||
                 a == ADDR_V_HOLD || a == ADDR_V_HOLD_RC)
            n = 2'd3;
        return n;
    endfunction : xfer_bytes

    // Absolute value of a signed sample, most negative code saturated
    function automatic logic [23:0] abs24(input logic signed [23:0] x);
        logic [23:0] r;
        r = x;
        if (x[23])
            r = (x == -24'sd8388608) ? ABS_MAX : 24'(-x);
        return r;
    endfunction : abs24

endpackage : meter_irq_pkg

// [test/peak_detect_irq_status_bench.sv]
// Self-checking bench for the peak, flag and interrupt block.
// Assumes serial_host masters the port and the interrupt wire is pulled up.
`timescale 1ns/100ps
module peak_detect_irq_status_bench;
    logic                   i_clk = 1'b0, i_rst = 1'b1, i_zc = 1'b0;
    logic [7:0]             i_temp_code = 8'h00, thr_v = 8'hFF, thr_i = 8'hFF;
    meter_irq_pkg::sample_t i_sample = '0;                    // Converter input
    wire                    sclk, cs_n, din, dout, dout_oe, irq_n, irq_oe, route;
    wire                    irq_wire = irq_oe ? irq_n : 1'b1;  // Pulled-up line
    int                     seed = 61, num_errors = 0, checked = 0, n;
    logic [23:0]            rd, snap, vhold = '0, ihold = '0; // Model peak holds
    logic [15:0]            flags = '0;                       // Model flag word
    logic signed [23:0]     v, c;
    // Device and host
    meter_irq_core i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_sample(i_sample),
        .i_zero_cross(i_zc), .i_temp_code(i_temp_code), .o_temp_route(route),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din), .o_dout(dout), .o_dout_oe(dout_oe),
        .o_irq_n(irq_n), .o_irq_oe(irq_oe));
    serial_host i_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout),
        .i_irq(irq_wire));
    always #4 i_clk = ~i_clk;  // 125 MHz master clock
    // Compare, count and report
    task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
        checked++;
        num_errors += int'(got !== exp);
        if (got !== exp) $display("wrong value %s expected %h seen %h", what, exp, got);
    endtask : chk
    // Register access, then time for the word to cross domains
    task automatic acc(logic rw, logic [5:0] a, logic [23:0] d);
        i_host.frame({rw, 1'b0, a}, (a < 6'h0D) ? 2 : (a inside {[6'h22:6'h25]}) ? 3 : 1,
                     d, rd);
        repeat (6) @(negedge i_clk);
    endtask : acc
    task automatic rd_chk(logic [5:0] a, logic [23:0] exp);
        acc(1'b0, a, 24'h00_0000);
        chk($sformatf("reg %h", a), exp, rd);
    endtask : rd_chk
    // One sample pair; the model doubles the voltage magnitude and compares bits 22:15 of the current magnitude
    task automatic send(logic signed [23:0] sv, logic signed [23:0] sc);
        logic [23:0] dv, ac;
        dv = (sv[23] ? 24'(-sv) : sv) << 1;
        ac = sc[23] ? 24'(-sc) : sc;
        if (dv[23:16] > thr_v) flags[8] = 1'b1;
        if (ac[22:15] > thr_i) flags[7] = 1'b1;
        if (dv > vhold) vhold = dv;
        if (ac > ihold) ihold = ac;
        @(negedge i_clk) i_sample = {1'b1, sv, sc};
        @(negedge i_clk) i_sample.valid = 1'b0;
    endtask : send
    // Verdict, also reached by the watchdog
    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    // Watchdog; the sequence needs about 36 us
    initial begin
        #400_000;
        num_errors++;
        give_verdict();
    end
    // Main sequence; inputs change at falling clock edges
    initial begin
        repeat (12) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        rd_chk(6'h21, 24'h00_00FF);
        // Boundary thresholds while the mask is clear
        thr_i = 8'h50;
        thr_v = 8'h00;
        acc(1'b1, 6'h20, 24'h00_0050);
        acc(1'b1, 6'h21, 24'h00_0000);
        send(24'sh00_7FFF, 24'sh28_51EC);
        rd_chk(6'h0B, 24'h00_0000);
        send(24'sh00_8000, -24'sh28_51EC);
        rd_chk(6'h0B, {8'h00, flags});
        chk("line", 24'h00_0001, 24'(irq_wire));
        acc(1'b1, 6'h0A, 24'h00_01A0);
        rd_chk(6'h0A, 24'h00_01A0);
        chk("line", 24'h00_0000, 24'(irq_wire));
        // Clearing read; a reported and a new event both arrive mid-transfer
        snap = {8'h00, flags};
        flags = flags & ~snap[15:0];
        fork
            i_host.service(rd);
            begin
                wait (i_host.bit_idx == 8);
                chk("line", 24'h00_0001, 24'(irq_wire));
                chk("drive", 24'h00_0001, 24'(dout_oe));
                send(24'sh00_8000, 24'sh30_0000);
                wait (i_host.bit_idx == 20);
                chk("line", 24'h00_0001, 24'(irq_wire));
            end
        join
        chk("flags", snap, rd);
        chk("drive", 24'h00_0000, 24'(dout_oe));
        repeat (8) @(negedge i_clk);
        chk("line", 24'h00_0000, 24'(irq_wire));
        i_host.service(rd);
        chk("flags", {8'h00, flags}, rd);
        repeat (8) @(negedge i_clk);
        chk("line", 24'h00_0001, 24'(irq_wire));
        // Random thresholds and samples on both channels
        thr_v = 8'($random(seed));
        thr_i = 8'($random(seed));
        acc(1'b1, 6'h21, {16'h0000, thr_v});
        acc(1'b1, 6'h20, {16'h0000, thr_i});
        flags = 16'h0000;
        for (n = 0; n < 20; n++) begin
            v = 24'($random(seed) % 32'sh0040_0000);
            c = 24'($random(seed) % 32'sh0040_0000);
            send(v, c);
        end
        rd_chk(6'h24, vhold);
        rd_chk(6'h25, vhold);
        rd_chk(6'h24, 24'h00_0000);
        rd_chk(6'h23, ihold);
        rd_chk(6'h22, 24'h00_0000);
        i_host.service(rd);
        chk("flags", {8'h00, flags}, rd);
        // Armed temperature conversion started by a crossing
        @(negedge i_clk) i_temp_code = 8'($random(seed)) | 8'h80;
        acc(1'b1, 6'h09, 24'h00_0020);
        i_zc = 1'b1;
        @(negedge i_clk);
        i_zc = 1'b0;
        for (n = 0; route === 1'b1 && n < 200; n++) @(negedge i_clk);
        chk("route", 24'h00_0060, 24'(n));
        repeat (2) @(negedge i_clk);
        chk("line", 24'h00_0000, 24'(irq_wire));
        chk("latch", 24'h00_0001, 24'(i_host.irq_latch));
        rd_chk(6'h26, {16'h0000, i_temp_code});
        i_host.service(rd);
        chk("flags", 24'h00_0020, rd);
        give_verdict();
    end
endmodule : peak_detect_irq_status_bench

// [test/serial_host.sv]
// Behavioural host that masters the serial port of the device.
// Assumes the device samples on falling and drives on rising clock edges.
`timescale 1ns/100ps
module serial_host (
    // Serial port, clock idle high
    output logic      o_sclk = 1'b1,
    output logic      o_cs_n = 1'b1,
    output logic      o_din  = 1'b0,
    input  wire logic i_dout,
    // Pulled-up interrupt wire
    input  wire logic i_irq
);
    logic irq_latch = 1'b0;  // Host interrupt request latch
    int   bit_idx   = 0;     // Bits clocked in this frame
    // Host input reacts to the falling edge only
    always @(negedge i_irq) irq_latch = 1'b1;
    // Command byte then nb data bytes, MSB first
    task automatic frame(input logic [7:0] cmd, input int nb, input logic [23:0] wd,
                         output logic [23:0] rd);
        logic [31:0] sh;
        sh = {cmd, wd << (8 * (3 - nb))};
        rd = 24'h00_0000;
        #3 o_cs_n = 1'b0;
        for (bit_idx = 0; bit_idx < 8 * nb + 8; bit_idx++) begin
            o_din = sh[31];
            sh = sh << 1;
            #40 o_sclk = 1'b0;
            rd = {rd[22:0], i_dout};
            // Longer gap after the command lets read data cross domains
            #((bit_idx == 7) ? 96 : 24) o_sclk = 1'b1;
        end
        #24 o_cs_n = 1'b1;
        o_din = ~o_din;  // Released line shows no stale value
        #48 rd = rd & ~(24'hFF_FFFF << (8 * nb));
    endtask : frame
    // Service: drop own request, then read the flags with clear
    task automatic service(output logic [23:0] fl);
        irq_latch = 1'b0;
        frame({2'b00, meter_irq_pkg::ADDR_FLAGS_RC}, 2, 24'h00_0000, fl);
    endtask : service
endmodule : serial_host
